// *** hw/branch_skip_pkg.sv ***
// types and constants shared by the branch, skip and miscellaneous execution slice
// assumes a byte-wide data path, a 16-bit program word and a word-wide avalon slave
package branch_skip_pkg;

	// program memory geometry and retire counter width
	localparam int PROG_ADDR_W = 13;
	localparam int PROG_WORD_W = 16;
	localparam int TABLE_HIGH_LATCH_W = PROG_WORD_W - 8;
	localparam int PAGE_W = PROG_ADDR_W - 8;
	localparam int RETIRED_W = 16;

	// register map, byte addresses
	localparam int AVS_ADDR_W = 4;
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] RETIRED_OFFSET = 4'h8;

	// field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int STATUS_TIMEOUT_BIT = 0;
	localparam int STATUS_PDFLAG_BIT = 1;
	localparam int STATUS_POWERDOWN_BIT = 2;
	localparam int STATUS_BUSY_BIT = 3;

	// reset values
	localparam logic CTRL_ENABLE_RESET = 1'b1;
	localparam logic WAITREQ_RESET = 1'b1;

	typedef enum logic [4:0] {
		NOP_OP, JUMP_OP, CALL_OP, RETURN_OP, RETURN_IMM_OP, INTERRUPT_RETURN_OP,
		SKIP_ZERO_OP, SKIP_ZERO_MOVE_OP, SKIP_BIT_CLEAR_OP, SKIP_BIT_SET_OP,
		INC_SKIP_OP, DEC_SKIP_OP, INC_SKIP_ACC_OP, DEC_SKIP_ACC_OP,
		TABLE_READ_OP, TABLE_READ_LAST_PAGE_OP, WATCHDOG_CLEAR_OP,
		WATCHDOG_PRECLEAR_FIRST, WATCHDOG_PRECLEAR_SECOND,
		NIBBLE_SWAP_OP, NIBBLE_SWAP_ACC_OP, POWER_DOWN_OP
	} op_t;

	typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} prelast_t;

	typedef struct packed {
		op_t op;
		logic [2:0] bitSel;
		logic [7:0] memByte;
		logic [7:0] immByte;
		logic writesPcl;
		logic [PAGE_W-1:0] tablePage;
		logic [7:0] tablePtr;
	} instr_t;

	typedef struct packed {
		logic accWe;
		logic [7:0] accData;
		logic memWe;
		logic [7:0] memData;
		logic tblhWe;
		logic [TABLE_HIGH_LATCH_W-1:0] tblhData;
		logic skipNext;
		logic pcLoad;
		logic stackPush;
		logic stackPop;
		logic intReenable;
		logic wdtRestart;
	} res_t;

	typedef struct packed {
		logic ready;
		logic busy;
		logic tablePending;
		logic [PROG_ADDR_W-1:0] progAddr;
		logic progRead;
		res_t res;
		logic done;
		logic timeoutFlag;
		logic powerdownFlag;
		logic powerDown;
		prelast_t lastPre;
		logic execEnable;
		logic waitReq;
		logic [31:0] readData;
		logic [RETIRED_W-1:0] retired;
	} state_t;

endpackage

// *** hw/skip_exec_alu.sv ***
// combinational result and skip decision for one issued instruction
// assumes the memory byte operand is already read and valid with the instruction
`timescale 1ns/1ps
module skip_exec_alu
	import branch_skip_pkg::*;
(
	input branch_skip_pkg::instr_t instr,
	output branch_skip_pkg::res_t res,
	output logic twoCycle,
	output logic isTable,
	output logic lastPage
);

	// zero test shared by the zero, increment and decrement skips
	function automatic logic isZero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	logic [7:0] incByte;
	logic [7:0] decByte;
	logic [7:0] swapByte;
	logic skip;

	assign incByte = instr.memByte + 8'h01;
	assign decByte = instr.memByte - 8'h01;
	assign swapByte = {instr.memByte[3:0], instr.memByte[7:4]};

	// decode; no status flag is ever touched here
	always_comb begin
		res = '0;
		skip = 1'b0;
		isTable = 1'b0;
		lastPage = 1'b0;
		case (instr.op)
			JUMP_OP: res.pcLoad = 1'b1;
			CALL_OP: begin
				res.pcLoad = 1'b1;
				res.stackPush = 1'b1;
			end
			RETURN_OP: res.stackPop = 1'b1;
			RETURN_IMM_OP: begin
				res.stackPop = 1'b1;
				res.accWe = 1'b1;
				res.accData = instr.immByte;
			end
			INTERRUPT_RETURN_OP: begin
				res.stackPop = 1'b1;
				res.intReenable = 1'b1;
			end
			SKIP_ZERO_OP: skip = isZero(instr.memByte);
			SKIP_ZERO_MOVE_OP: begin
				res.accWe = 1'b1;
				res.accData = instr.memByte;
				skip = isZero(instr.memByte);
			end
			SKIP_BIT_CLEAR_OP: skip = !instr.memByte[instr.bitSel];
			SKIP_BIT_SET_OP: skip = instr.memByte[instr.bitSel];
			INC_SKIP_OP: begin
				res.memWe = 1'b1;
				res.memData = incByte;
				skip = isZero(incByte);
			end
			DEC_SKIP_OP: begin
				res.memWe = 1'b1;
				res.memData = decByte;
				skip = isZero(decByte);
			end
			INC_SKIP_ACC_OP: begin
				res.accWe = 1'b1;
				res.accData = incByte;
				skip = isZero(incByte);
			end
			DEC_SKIP_ACC_OP: begin
				res.accWe = 1'b1;
				res.accData = decByte;
				skip = isZero(decByte);
			end
			TABLE_READ_OP: isTable = 1'b1;
			TABLE_READ_LAST_PAGE_OP: begin
				isTable = 1'b1;
				lastPage = 1'b1;
			end
			NIBBLE_SWAP_OP: begin
				res.memWe = 1'b1;
				res.memData = swapByte;
			end
			NIBBLE_SWAP_ACC_OP: begin
				res.accWe = 1'b1;
				res.accData = swapByte;
			end
			default: res = '0;
		endcase
		res.skipNext = skip;
	end

	// second cycle for a skip, a pcl write, a branch, a return or a table fetch
	assign twoCycle = skip || instr.writesPcl || isTable || res.pcLoad || res.stackPop;

endmodule // skip_exec_alu

// *** hw/branch_skip_exec.sv ***
// execution slice for branch, skip, return, table read and miscellaneous instructions
// assumes the fetch stage holds issueValid and the instruction until issueReady is seen,
// and that program memory returns progWord in the cycle in which progRead is high
`timescale 1ns/1ps
module branch_skip_exec
	import branch_skip_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic issueValid,
	input branch_skip_pkg::instr_t instr,
	output logic issueReady,
	output branch_skip_pkg::res_t result,
	output logic retireDone,
	output logic progRead,
	output logic [branch_skip_pkg::PROG_ADDR_W-1:0] progAddr,
	input wire logic [branch_skip_pkg::PROG_WORD_W-1:0] progWord,
	input wire logic wdtTimeout,
	input wire logic wakeup,
	output logic timeoutFlag,
	output logic powerdownFlag,
	output logic powerDown,
	input wire logic [branch_skip_pkg::AVS_ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest
);
	import branch_skip_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// geometry checks

	if (PROG_ADDR_W < 9 || PROG_WORD_W < 9) begin : g_geom_check
		$error("program memory geometry too small for a byte pointer and high latch");
	end

	////////////////////////////////////////////////////////////////////////////
	// decode

	res_t aluRes;
	logic aluTwo;
	logic aluTable;
	logic aluLast;
	logic issue;
	state_t st;
	state_t next_st;

	skip_exec_alu u_alu (
		.instr(instr),
		.res(aluRes),
		.twoCycle(aluTwo),
		.isTable(aluTable),
		.lastPage(aluLast)
	);

	assign issue = issueValid && st.ready;

	// register read mux
	function automatic logic [31:0] regRead(input logic [3:0] addr, input state_t s);
		logic [31:0] v;
		v = '0;
		case (addr)
			CTRL_OFFSET: v[CTRL_ENABLE_BIT] = s.execEnable;
			STATUS_OFFSET: begin
				v[STATUS_TIMEOUT_BIT] = s.timeoutFlag;
				v[STATUS_PDFLAG_BIT] = s.powerdownFlag;
				v[STATUS_POWERDOWN_BIT] = s.powerDown;
				v[STATUS_BUSY_BIT] = s.busy;
			end
			RETIRED_OFFSET: v[RETIRED_W-1:0] = s.retired;
			default: v = '0; // unmapped reads as zero
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		next_st.res = '0;
		next_st.progRead = 1'b0;
		next_st.done = 1'b0;
		next_st.busy = 1'b0;
		next_st.tablePending = 1'b0;

		// second cycle of a two-cycle instruction; issue is blocked meanwhile
		if (st.busy) begin
			next_st.done = 1'b1;
			if (st.tablePending) begin
				next_st.res.tblhWe = 1'b1;
				next_st.res.tblhData = progWord[PROG_WORD_W-1:8];
				next_st.res.memWe = 1'b1;
				next_st.res.memData = progWord[7:0];
			end
		end

		if (issue) begin
			next_st.res = aluRes;
			next_st.busy = aluTwo;
			next_st.done = !aluTwo;
			if (aluTable) begin
				next_st.tablePending = 1'b1;
				next_st.progRead = 1'b1;
				// last page forces every page bit high
				next_st.progAddr = aluLast ? {{PAGE_W{1'b1}}, instr.tablePtr}
					: {instr.tablePage, instr.tablePtr};
			end

			// watchdog and power-down flag handling
			next_st.lastPre = PRE_NONE;
			case (instr.op)
				WATCHDOG_CLEAR_OP: begin
					next_st.res.wdtRestart = 1'b1;
					next_st.timeoutFlag = 1'b0;
					next_st.powerdownFlag = 1'b0;
				end
				WATCHDOG_PRECLEAR_FIRST: begin
					if (st.lastPre == PRE_SECOND) begin
						next_st.res.wdtRestart = 1'b1;
						next_st.timeoutFlag = 1'b0;
						next_st.powerdownFlag = 1'b0;
					end else begin
						next_st.lastPre = PRE_FIRST;
					end
				end
				WATCHDOG_PRECLEAR_SECOND: begin
					if (st.lastPre == PRE_FIRST) begin
						next_st.res.wdtRestart = 1'b1;
						next_st.timeoutFlag = 1'b0;
						next_st.powerdownFlag = 1'b0;
					end else begin
						next_st.lastPre = PRE_SECOND;
					end
				end
				POWER_DOWN_OP: begin
					next_st.timeoutFlag = 1'b0;
					next_st.powerdownFlag = 1'b1;
					next_st.powerDown = 1'b1;
				end
				default: next_st.lastPre = PRE_NONE;
			endcase
		end

		// a timeout in the same cycle as a clear still lands
		if (wdtTimeout) begin
			next_st.timeoutFlag = 1'b1;
			next_st.powerDown = 1'b0;
		end
		if (wakeup) begin
			next_st.powerDown = 1'b0;
		end

		// avalon slave: one wait state, data sampled when waitrequest drops
		if ((avsRead || avsWrite) && st.waitReq) begin
			next_st.waitReq = 1'b0;
			next_st.readData = avsRead ? regRead(avsAddress, st) : 32'h0000_0000;
		end else begin
			next_st.waitReq = 1'b1;
			if (!st.waitReq && avsWrite && avsByteEnable[0]) begin
				case (avsAddress)
					CTRL_OFFSET: next_st.execEnable = avsWriteData[CTRL_ENABLE_BIT];
					STATUS_OFFSET: begin
						// a power down instruction taken in this same cycle wins over the software wake
						if (avsWriteData[STATUS_POWERDOWN_BIT] && !(issue && instr.op == POWER_DOWN_OP)) begin
							next_st.powerDown = 1'b0; // software wake
						end
					end
					RETIRED_OFFSET: next_st.retired = '0;
					default: next_st.retired = next_st.retired; // unmapped write ignored
				endcase
			end
		end

		// count after the clear so a retire in the clearing cycle survives
		if (st.done) begin
			next_st.retired = next_st.retired + RETIRED_W'(1);
		end

		// ready only when idle, enabled and awake
		next_st.ready = !next_st.busy && next_st.execEnable && !next_st.powerDown;
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
			st.execEnable <= CTRL_ENABLE_RESET;
			st.waitReq <= WAITREQ_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign issueReady = st.ready;
	assign result = st.res;
	assign retireDone = st.done;
	assign progRead = st.progRead;
	assign progAddr = st.progAddr;
	assign timeoutFlag = st.timeoutFlag;
	assign powerdownFlag = st.powerdownFlag;
	assign powerDown = st.powerDown;
	assign avsReadData = st.readData;
	assign avsWaitRequest = st.waitReq;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	logic skipOp;
	assign skipOp = instr.op inside {SKIP_ZERO_OP, SKIP_ZERO_MOVE_OP, SKIP_BIT_CLEAR_OP,
		SKIP_BIT_SET_OP, INC_SKIP_OP, DEC_SKIP_OP, INC_SKIP_ACC_OP, DEC_SKIP_ACC_OP};

	AST_SKIP_TAKES_TWO: assert property (
		issue && skipOp && aluRes.skipNext |=> result.skipNext && !issueReady ##1 retireDone)
		else $error("skip did not occupy two cycles");

	AST_NOSKIP_TAKES_ONE: assert property (
		issue && skipOp && !aluRes.skipNext && !instr.writesPcl |=> retireDone && !result.skipNext)
		else $error("non-skipping test did not retire in one cycle");

	AST_PCL_WRITE_TWO: assert property (
		issue && instr.writesPcl |=> !retireDone && !issueReady ##1 retireDone)
		else $error("pcl write did not take two cycles");

	AST_PAIR_CLEARS: assert property (
		issue && instr.op == WATCHDOG_PRECLEAR_SECOND && st.lastPre == PRE_FIRST && !wdtTimeout
		|=> !timeoutFlag && !powerdownFlag && result.wdtRestart)
		else $error("back to back pre-clears left a flag set");

	AST_SINGLE_PRECLEAR_HOLDS: assert property (
		issue && instr.op == WATCHDOG_PRECLEAR_FIRST && st.lastPre != PRE_SECOND && !wdtTimeout
		|=> timeoutFlag == $past(timeoutFlag) && powerdownFlag == $past(powerdownFlag))
		else $error("lone pre-clear changed a flag");

	AST_ZERO_MOVE: assert property (
		issue && instr.op == SKIP_ZERO_MOVE_OP |=> result.accWe && !result.memWe
		&& result.accData == $past(instr.memByte) && result.skipNext == ($past(instr.memByte) == 8'h00))
		else $error("zero-move result or skip wrong");

	AST_BIT_SKIP: assert property (
		issue && instr.op inside {SKIP_BIT_SET_OP, SKIP_BIT_CLEAR_OP}
		|=> result.skipNext == ($past(instr.memByte[instr.bitSel]) == ($past(instr.op) == SKIP_BIT_SET_OP))
		&& !result.accWe && !result.memWe)
		else $error("bit skip decision wrong");

	AST_INC_ACC: assert property (
		issue && instr.op == INC_SKIP_ACC_OP |=> result.accWe && !result.memWe
		&& result.accData == 8'($past(instr.memByte) + 8'h01) && result.skipNext == (result.accData == 8'h00))
		else $error("increment to acc wrong");

	AST_DEC_ACC: assert property (
		issue && instr.op == DEC_SKIP_ACC_OP |=> result.accWe && !result.memWe
		&& result.accData == 8'($past(instr.memByte) - 8'h01) && result.skipNext == (result.accData == 8'h00))
		else $error("decrement to acc wrong");

	AST_RETURN_TWO: assert property (
		issue && instr.op inside {RETURN_OP, RETURN_IMM_OP, INTERRUPT_RETURN_OP} && !wdtTimeout
		|=> result.stackPop && !retireDone && $stable(timeoutFlag) ##1 retireDone)
		else $error("return did not take two cycles");

	AST_TABLE_READ: assert property (
		issue && instr.op == TABLE_READ_OP |=> progRead && progAddr == {$past(instr.tablePage), $past(instr.tablePtr)}
		##1 result.tblhWe && result.memWe && result.tblhData == $past(progWord[PROG_WORD_W-1:8])
		&& result.memData == $past(progWord[7:0]) && retireDone)
		else $error("table read data or timing wrong");

	AST_TABLE_LAST_PAGE: assert property (
		issue && instr.op == TABLE_READ_LAST_PAGE_OP
		|=> progRead && progAddr[PROG_ADDR_W-1:8] == {PAGE_W{1'b1}} ##1 result.tblhWe && retireDone)
		else $error("last page table read wrong");

	AST_POWER_DOWN: assert property (
		issue && instr.op == POWER_DOWN_OP && !wdtTimeout && !wakeup
		|=> powerDown && powerdownFlag && !timeoutFlag && !issueReady)
		else $error("power down did not set mode and flags");

	AST_SWAP_ACC: assert property (
		issue && instr.op == NIBBLE_SWAP_ACC_OP
		|=> result.accWe && result.accData == {$past(instr.memByte[3:0]), $past(instr.memByte[7:4])})
		else $error("nibble swap to acc wrong");

	AST_WDT_CLEAR: assert property (
		issue && instr.op == WATCHDOG_CLEAR_OP && !wdtTimeout
		|=> result.wdtRestart && retireDone && !timeoutFlag && !powerdownFlag)
		else $error("watchdog clear not single cycle");

	AST_BRANCH_TWO: assert property (
		issue && instr.op inside {JUMP_OP, CALL_OP} |=> result.pcLoad && !retireDone ##1 retireDone)
		else $error("jump or call not two cycles");

	AST_REVERSE_PAIR_CLEARS: assert property (
		issue && instr.op == WATCHDOG_PRECLEAR_FIRST && st.lastPre == PRE_SECOND && !wdtTimeout
		|=> !timeoutFlag && !powerdownFlag && result.wdtRestart)
		else $error("pre-clears in reverse order left a flag set");

	AST_LONE_SECOND_HOLDS: assert property (
		issue && instr.op == WATCHDOG_PRECLEAR_SECOND && st.lastPre != PRE_FIRST && !wdtTimeout
		|=> $stable(timeoutFlag) && $stable(powerdownFlag) && !result.wdtRestart)
		else $error("lone second pre-clear changed a flag");

	// any other instruction between the two pre-clears must break the pair
	AST_OTHER_BREAKS_PAIR: assert property (
		issue && !(instr.op inside {WATCHDOG_PRECLEAR_FIRST, WATCHDOG_PRECLEAR_SECOND})
		|=> st.lastPre == PRE_NONE)
		else $error("pre-clear pairing survived another instruction");

	AST_DATA_OPS_KEEP_FLAGS: assert property (
		issue && !wdtTimeout
		&& (skipOp || instr.op inside {NIBBLE_SWAP_ACC_OP, TABLE_READ_OP, TABLE_READ_LAST_PAGE_OP})
		|=> $stable(timeoutFlag) && $stable(powerdownFlag))
		else $error("data or table instruction changed a status flag");

	AST_ASLEEP_REFUSES: assert property (
		powerDown |-> !issueReady)
		else $error("instruction accepted in power down");

	AST_TIMEOUT_SETS: assert property (
		wdtTimeout |=> timeoutFlag && !powerDown)
		else $error("watchdog timeout did not set its flag and wake");

	COV_SKIP_TAKEN: cover property (issue && skipOp && aluRes.skipNext);
	COV_PRECLEAR_PAIR: cover property (issue && instr.op == WATCHDOG_PRECLEAR_FIRST
		##[1:4] issue && instr.op == WATCHDOG_PRECLEAR_SECOND);
	COV_TABLE_LAST: cover property (issue && instr.op == TABLE_READ_LAST_PAGE_OP);
	COV_PAIR_REVERSE: cover property (issue && instr.op == WATCHDOG_PRECLEAR_FIRST && st.lastPre == PRE_SECOND);
	COV_HALT_WAKE: cover property (powerDown ##[1:20] !powerDown);

endmodule // branch_skip_exec

// *** verification/branch_skip_exec_tb.sv ***
// self-checking bench for the branch, skip and miscellaneous execution slice
// assumes the designer's reset, issue and avalon timing; the bench plays fetch, program memory and watchdog
`timescale 1ns/1ps
module branch_skip_exec_tb;
	import branch_skip_pkg::*;

	`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
		$display("FAIL time=%0t got=%0h exp=%0h", $time, (a), (b)); end end

	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic issueValid = 1'b0;
	instr_t instr = '0;
	logic issueReady, retireDone, progRead, timeoutFlag, powerdownFlag, powerDown, avsWaitRequest;
	res_t result;
	logic [PROG_ADDR_W-1:0] progAddr;
	logic [PROG_WORD_W-1:0] tblWord = 16'h0000;
	logic [PROG_WORD_W-1:0] progWord;
	logic wdtTimeout = 1'b0;
	logic wakeup = 1'b0;
	logic [AVS_ADDR_W-1:0] avsAddress = 4'h0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h00000000;
	logic [3:0] avsByteEnable = 4'hf;
	logic [31:0] avsReadData, rd;
	int n_tests = 0;
	int n_mismatch = 0;
	logic [1:0] flagsExp = 2'b00;
	logic prC1;
	logic [PROG_ADDR_W-1:0] paC1;
	res_t r, r2;

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	branch_skip_exec u_branch_skip_exec (.clk_sys(clk_sys), .rst(rst), .issueValid(issueValid), .instr(instr),
		.issueReady(issueReady), .result(result), .retireDone(retireDone), .progRead(progRead),
		.progAddr(progAddr), .progWord(progWord), .wdtTimeout(wdtTimeout), .wakeup(wakeup),
		.timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .powerDown(powerDown),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));

	// program memory answers only while the fetch is out; the inverse elsewhere exposes a mistimed sample
	assign progWord = progRead ? tblWord : ~tblWord;

	////////////////////////////////////////////////////////////////////////////////
	// verdict and run end, shared by the main sequence and every expired wait
	task final_report;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// bounded wait for waitrequest low, seen at the rising edge just as the slave sees it
	task avs_wait;
		int k;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (avsWaitRequest === 1'b0) break;
		end
		if (k == 50) begin
			n_mismatch++;
			final_report;
		end
	endtask

	task avs_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avsAddress <= a;
		avsWriteData <= d;
		avsByteEnable <= be;
		avsWrite <= 1'b1;
		avs_wait;
		avsWrite <= 1'b0;
		avsWriteData <= ~d;
	endtask

	// read data stand at the edge that sees waitrequest low, and are taken there
	task avs_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		avsAddress <= a;
		avsRead <= 1'b1;
		avs_wait;
		d = avsReadData;
		avsRead <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// instruction builder; table pointer is fixed so addresses are easy to predict
	function automatic instr_t mk(input op_t op, input logic [7:0] m, input logic [2:0] b, input logic [7:0] imm,
		input logic pc_low_byte, input logic [PAGE_W-1:0] pg);
		instr_t i;
		i = '0;
		i.op = op;
		i.memByte = m;
		i.bitSel = b;
		i.immByte = imm;
		i.writesPcl = pc_low_byte;
		i.tablePage = pg;
		i.tablePtr = 8'h44;
		return i;
	endfunction

	// issue one instruction and check its retire moment against the expected cycle count
	task run_op(input instr_t i, input logic two, output res_t q1, output res_t q2);
		int k;
		@(posedge clk_sys);
		instr <= i;
		issueValid <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge clk_sys);
			if (issueReady === 1'b1) break;
		end
		if (k == 50) begin
			n_mismatch++;
			final_report;
		end
		@(posedge clk_sys);
		issueValid <= 1'b0;
		@(negedge clk_sys);
		q1 = result;
		q2 = result;
		prC1 = progRead;
		paC1 = progAddr;
		`CHK(retireDone, ~two)
		if (two) begin
			`CHK(issueReady, 1'b0)
			@(negedge clk_sys);
			q2 = result;
			`CHK(retireDone, 1'b1)
		end
	endtask

	// data-memory tests: accumulator result, skip decision, memory untouched, flags kept
	task sk(input op_t op, input logic [7:0] m, input logic [2:0] b, input logic [7:0] acc, input logic aw,
		input logic s);
		run_op(mk(op, m, b, 8'h00, 1'b0, '0), s, r, r2);
		`CHK(r.skipNext, s)
		`CHK(r.accWe, aw)
		if (aw) `CHK(r.accData, acc)
		`CHK(r.memWe, 1'b0)
		`CHK({timeoutFlag, powerdownFlag}, flagsExp)
	endtask

	task wdt_pulse;
		@(posedge clk_sys);
		wdtTimeout <= 1'b1;
		@(posedge clk_sys);
		wdtTimeout <= 1'b0;
		@(negedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		avs_rd(STATUS_OFFSET, rd);
		`CHK(rd, 32'h00000000)
		avs_rd(4'hc, rd);
		`CHK(rd, 32'h00000000)
		avs_wr(CTRL_OFFSET, 32'h00000000, 4'h0);
		avs_rd(CTRL_OFFSET, rd);
		`CHK(rd, 32'h00000001)
		$display("test registers done");

		// a raised timeout flag must survive every instruction other than the watchdog clears and power down
		wdt_pulse;
		flagsExp = 2'b10;
		`CHK({timeoutFlag, powerdownFlag}, flagsExp)
		sk(SKIP_ZERO_MOVE_OP, 8'h00, 3'd0, 8'h00, 1'b1, 1'b1);
		sk(SKIP_ZERO_MOVE_OP, 8'h5a, 3'd0, 8'h5a, 1'b1, 1'b0);
		sk(SKIP_BIT_CLEAR_OP, 8'hf7, 3'd3, 8'h00, 1'b0, 1'b1);
		sk(SKIP_BIT_CLEAR_OP, 8'h08, 3'd3, 8'h00, 1'b0, 1'b0);
		sk(SKIP_BIT_SET_OP, 8'h80, 3'd7, 8'h00, 1'b0, 1'b1);
		sk(SKIP_BIT_SET_OP, 8'h7f, 3'd7, 8'h00, 1'b0, 1'b0);
		sk(INC_SKIP_ACC_OP, 8'hff, 3'd0, 8'h00, 1'b1, 1'b1);
		sk(INC_SKIP_ACC_OP, 8'h10, 3'd0, 8'h11, 1'b1, 1'b0);
		sk(DEC_SKIP_ACC_OP, 8'h01, 3'd0, 8'h00, 1'b1, 1'b1);
		sk(DEC_SKIP_ACC_OP, 8'h00, 3'd0, 8'hff, 1'b1, 1'b0);
		sk(NIBBLE_SWAP_ACC_OP, 8'ha5, 3'd0, 8'h5a, 1'b1, 1'b0);
		run_op(mk(SKIP_ZERO_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b1, r, r2);
		`CHK({r.skipNext, r.accWe, r.memWe}, 3'b100)
		run_op(mk(INC_SKIP_OP, 8'h10, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({r.skipNext, r.accWe, r.memWe, r.memData}, {3'b001, 8'h11})
		run_op(mk(DEC_SKIP_OP, 8'h01, 3'd0, 8'h00, 1'b0, '0), 1'b1, r, r2);
		`CHK({r.skipNext, r.accWe, r.memWe, r.memData}, {3'b101, 8'h00})
		run_op(mk(NIBBLE_SWAP_OP, 8'ha5, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({r.skipNext, r.accWe, r.memWe, r.memData}, {3'b001, 8'h5a})
		$display("test skips done");

		// returns, jump, call and a plain op that writes the low program counter byte
		run_op(mk(RETURN_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b1, r, r2);
		`CHK(r.stackPop, 1'b1)
		run_op(mk(RETURN_IMM_OP, 8'h00, 3'd0, 8'h3c, 1'b0, '0), 1'b1, r, r2);
		`CHK({r.stackPop, r.accWe, r.accData}, {2'b11, 8'h3c})
		run_op(mk(INTERRUPT_RETURN_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b1, r, r2);
		`CHK({r.stackPop, r.intReenable}, 2'b11)
		`CHK({timeoutFlag, powerdownFlag}, flagsExp)
		run_op(mk(JUMP_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b1, r, r2);
		`CHK(r.pcLoad, 1'b1)
		run_op(mk(CALL_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b1, r, r2);
		`CHK({r.pcLoad, r.stackPush}, 2'b11)
		run_op(mk(NOP_OP, 8'h00, 3'd0, 8'h00, 1'b1, '0), 1'b1, r, r2);
		$display("test branches done");

		// table reads; the word only stands while the fetch is out, otherwise it is inverted
		tblWord <= 16'hc35a;
		run_op(mk(TABLE_READ_OP, 8'h00, 3'd0, 8'h00, 1'b0, 5'h03), 1'b1, r, r2);
		`CHK({prC1, paC1}, {1'b1, 5'h03, 8'h44})
		`CHK({r2.tblhWe, r2.tblhData, r2.memWe, r2.memData}, {1'b1, 8'hc3, 1'b1, 8'h5a})
		tblWord <= 16'h3ca5;
		run_op(mk(TABLE_READ_LAST_PAGE_OP, 8'h00, 3'd0, 8'h00, 1'b0, 5'h03), 1'b1, r, r2);
		`CHK({prC1, paC1}, {1'b1, 5'h1f, 8'h44})
		`CHK({r2.tblhWe, r2.tblhData, r2.memWe, r2.memData}, {1'b1, 8'h3c, 1'b1, 8'ha5})
		tblWord <= 16'hc35a;
		$display("test tables done");

		// power down, refusal while asleep, wake through the status register
		run_op(mk(POWER_DOWN_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		flagsExp = 2'b01;
		`CHK({timeoutFlag, powerdownFlag, powerDown}, 3'b011)
		@(negedge clk_sys);
		`CHK(issueReady, 1'b0)
		avs_wr(STATUS_OFFSET, 32'h00000004, 4'hf);
		avs_rd(STATUS_OFFSET, rd);
		`CHK(rd, 32'h00000002)
		$display("test power down done");

		// pre-clears split by another instruction leave the flags, back to back clears them
		run_op(mk(WATCHDOG_PRECLEAR_FIRST, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		run_op(mk(NOP_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		run_op(mk(WATCHDOG_PRECLEAR_SECOND, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({timeoutFlag, powerdownFlag, r.wdtRestart}, 3'b010)
		run_op(mk(NOP_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		run_op(mk(WATCHDOG_PRECLEAR_FIRST, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({timeoutFlag, powerdownFlag, r.wdtRestart}, 3'b010)
		run_op(mk(WATCHDOG_PRECLEAR_SECOND, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({timeoutFlag, powerdownFlag, r.wdtRestart}, 3'b001)
		wdt_pulse;
		`CHK({timeoutFlag, powerdownFlag}, 2'b10)
		run_op(mk(WATCHDOG_CLEAR_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({timeoutFlag, powerdownFlag, r.wdtRestart}, 3'b001)
		avs_rd(STATUS_OFFSET, rd);
		`CHK(rd, 32'h00000000)
		wdt_pulse;
		run_op(mk(WATCHDOG_PRECLEAR_SECOND, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({timeoutFlag, r.wdtRestart}, 2'b10)
		run_op(mk(WATCHDOG_PRECLEAR_FIRST, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		`CHK({timeoutFlag, powerdownFlag, r.wdtRestart}, 3'b001)
		$display("test watchdog done");

		// retire counter: cleared by a write to its offset with byte 0 enabled, then one count per finished instruction
		avs_wr(RETIRED_OFFSET, 32'h00000000, 4'hf);
		run_op(mk(NOP_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b0, r, r2);
		run_op(mk(JUMP_OP, 8'h00, 3'd0, 8'h00, 1'b0, '0), 1'b1, r, r2);
		avs_rd(RETIRED_OFFSET, rd);
		`CHK(rd, 32'h00000002)
		$display("test retire count done");
		final_report;
	end

endmodule // branch_skip_exec_tb
